// >>> rtl/link_tuning.v
`timescale 1ns/1ns
`include "link_tuning_defines.vh"
module link_tuning #(
    parameter AW = 12
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Register access
    input wire wr,
    input wire rd,
    input wire [AW-1:0] addr,
    input wire [31:0] wdata,
    output reg [31:0] rdata,
    // EEPROM load
    input wire ee_load,
    input wire [15:0] ee_data,
    // Transmit FIFO state
    input wire [11:0] fifo_fill,
    input wire packet_complete,
    input wire underrun,
    input wire packet_sent,
    input wire retries_zero,
    // Isochronous stream format
    input wire [5:0] stream_format_code,
    // Controls out
    output reg tx_start,
    output reg no_reorder_tx,
    output reg transport_stream_timestamp_on,
    output reg video_timestamp_on,
    output reg store_forward
);
    reg [15:0] ctrl;
    wire [15:0] next_ctrl;
    wire [15:0] wmask = `LT_WMASK;
    wire [15:0] ee_mask = `LT_EE_MASK;

    reg hit_set;
    reg hit_clr;
    reg hit_cfg;
    wire hit_any = hit_set || hit_clr || hit_cfg;
    wire wr_set = wr && hit_set;
    wire wr_clr = wr && hit_clr;
    wire wr_cfg = wr && hit_cfg;

    // Retry mode after an underrun
    localparam ST_THRESHOLD = 1'b0;
    localparam ST_RETRY = 1'b1;
    reg state;
    reg next_state;
    wire retry_sf = state == ST_RETRY;

    wire [1:0] thr_code = ctrl[`LT_THR_HI:`LT_THR_LO];
    reg [11:0] thr;
    reg next_store_forward;

    reg next_tx_start;
    reg [31:0] next_rdata;
    reg next_transport_stream_timestamp_on;
    reg next_video_timestamp_on;
    genvar i;

    // Address decode
    always @* begin
        hit_set = 1'b0;
        hit_clr = 1'b0;
        hit_cfg = 1'b0;
        if (addr == `LT_SET_ADDR) begin
            hit_set = 1'b1;
        end else if (addr == `LT_CLR_ADDR) begin
            hit_clr = 1'b1;
        end else if (addr == `LT_CFG_ADDR) begin
            hit_cfg = 1'b1;
        end
    end

    // One set/clear cell per control bit
    generate
        for (i = 0; i < 16; i = i + 1) begin : ctrl_bit
            reg bit_next;
            always @* begin
                bit_next = ctrl[i];
                if (ee_load) begin
                    if (ee_mask[i]) begin
                        bit_next = ee_data[i];
                    end
                end else if (wmask[i]) begin
                    if (wr_set && wdata[i]) begin
                        bit_next = 1'b1;
                    end else if (wr_clr && wdata[i]) begin
                        bit_next = 1'b0;
                    end else if (wr_cfg) begin
                        bit_next = wdata[i];
                    end
                end
            end
            assign next_ctrl[i] = bit_next;
        end
    endgenerate

    always @(posedge clk) begin
        if (!nrst) begin
            ctrl <= `LT_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    always @* begin
        next_state = state;
        case (state)
            ST_THRESHOLD: begin
                if (underrun) begin
                    next_state = ST_RETRY;
                end
            end
            ST_RETRY: begin
                if (!underrun && packet_sent) begin
                    next_state = ST_THRESHOLD;
                end
            end
        endcase
    end

    always @(posedge clk) begin
        if (!nrst) begin
            state <= ST_THRESHOLD;
        end else begin
            state <= next_state;
        end
    end

    always @* begin
        case (thr_code)
            2'b00: thr = `LT_THR_2K;
            2'b01: thr = `LT_THR_1K7;
            2'b10: thr = `LT_THR_1K;
            default: thr = `LT_THR_512;
        endcase
    end

    always @* begin
        next_store_forward = 1'b0;
        if (retry_sf) begin
            next_store_forward = 1'b1;
        end else if (retries_zero) begin
            next_store_forward = 1'b1;
        end else if (thr_code == 2'b00) begin
            next_store_forward = 1'b1;
        end
    end

    always @* begin
        next_tx_start = 1'b0;
        if (packet_complete) begin
            next_tx_start = 1'b1;
        end else if (!next_store_forward && fifo_fill >= thr) begin
            next_tx_start = 1'b1;
        end
    end

    always @* begin
        next_rdata = 32'h00000000;
        if (rd && hit_any) begin
            next_rdata = {16'h0000, ctrl & wmask};
        end
    end

    always @* begin
        next_transport_stream_timestamp_on = 1'b0;
        next_video_timestamp_on = 1'b0;
        if (ctrl[`LT_TS_ON] && stream_format_code == `LT_FMT_TS) begin
            next_transport_stream_timestamp_on = 1'b1;
        end
        if (ctrl[`LT_VID_ON] && stream_format_code == `LT_FMT_VID) begin
            next_video_timestamp_on = 1'b1;
        end
    end

    // Registered outputs
    always @(posedge clk) begin
        if (!nrst) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            tx_start <= 1'b0;
        end else begin
            tx_start <= next_tx_start;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            store_forward <= 1'b0;
        end else begin
            store_forward <= next_store_forward;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            no_reorder_tx <= 1'b0;
        end else begin
            no_reorder_tx <= ctrl[`LT_NO_REORDER];
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            transport_stream_timestamp_on <= 1'b0;
            video_timestamp_on <= 1'b0;
        end else begin
            transport_stream_timestamp_on <= next_transport_stream_timestamp_on;
            video_timestamp_on <= next_video_timestamp_on;
        end
    end
endmodule // link_tuning

// >>> rtl/link_tuning_defines.vh
// Behaviour
// - One value, write-one-sets at A88h, write-one-clears at A8Ch, reads mirror config copy.
// - Bits 31..16, 14, 11, 9, 6..2 and 0 read as zero.
// - Bit 15 set disables out-of-order asynchronous transmit pipelining.
// - Threshold field 13:12: 00 2K, 01 1.7K default, 10 1K, 11 512.
// - Programmed threshold used until underrun; retry uses 2K store-and-forward.
// - Below 2K, start at threshold fill or when whole packet is in FIFO.
// - After underrun switch to store-and-forward, resend only complete packet.
// - 2K threshold holds data until end-of-packet token received.
// - Zero retries register forces store-and-forward always.
// - Bit 10 enables transport stream timestamp for format code 20h.
// - Bit 8 enables video timestamp for format code 00h.
// - EEPROM may load some bits after reset; software may instead.
`ifndef LINK_TUNING_DEFINES_VH
`define LINK_TUNING_DEFINES_VH
`define LT_SET_ADDR 12'ha88
`define LT_CLR_ADDR 12'ha8c
`define LT_CFG_ADDR 12'h0f4
`define LT_RESET 16'h1000
`define LT_WMASK 16'hb582
`define LT_EE_MASK 16'h0082
`define LT_NO_REORDER 15
`define LT_THR_HI 13
`define LT_THR_LO 12
`define LT_TS_ON 10
`define LT_VID_ON 8
`define LT_THR_2K 12'h800
`define LT_THR_1K7 12'h6c0
`define LT_THR_1K 12'h400
`define LT_THR_512 12'h200
`define LT_FMT_TS 6'h20
`define LT_FMT_VID 6'h00
`endif

// >>> tb/tx_fifo_model.sv
`timescale 1ns/1ns
module tx_fifo_model (input wire clk, go, tx_start, output reg [11:0] fifo_fill = 0,
    output reg packet_complete = 0, packet_sent = 0);
    // Fills 64 bytes a cycle; the packet is whole at 960 bytes
    always @(posedge clk) begin
        fifo_fill <= go ? fifo_fill + 12'h040 : 12'h000;
        packet_complete <= go && fifo_fill >= 12'h3c0;
        packet_sent <= tx_start && !packet_sent;
    end
endmodule // tx_fifo_model

// >>> tb/link_tuning_checker.sv
`timescale 1ns/1ns
module link_tuning_checker (input wire clk, nrst, wr, packet_complete, underrun, retries_zero, tx_start,
    no_reorder_tx, store_forward, input wire [11:0] addr, input wire [31:0] wdata, rdata);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    rsvd_zero_a: assert property ((rdata & 32'hffff4a7d) == 32'h0) else $error("rsvd");
    set_bit_a: assert property (wr && addr == 12'ha88 && wdata[15] ##1 !wr |=> no_reorder_tx) else $error("set");
    clr_bit_a: assert property (wr && addr == 12'ha8c && wdata[15] ##1 !wr |=> !no_reorder_tx) else $error("clr");
    retry_zero_a: assert property ($past(nrst) && $past(retries_zero) |-> store_forward) else $error("rz");
    underrun_sf_a: assert property (underrun |-> ##2 store_forward) else $error("ur");
    full_start_a: assert property ($rose(packet_complete) |=> tx_start) else $error("st");
    sf_hold_a: assert property ($rose(tx_start) && store_forward |-> $past(packet_complete)) else $error("sf");
    write_rd_a: assert property (wr |=> rdata == 32'h0) else $error("wr");
endmodule // link_tuning_checker
bind link_tuning link_tuning_checker link_tuning_checker_inst (.*);

// >>> tb/link_tuning_bench.sv
`timescale 1ns/1ns
module link_tuning_bench;
    reg clk, nrst, wr, rd, ee_load, underrun, retries_zero, go;
    reg [11:0] addr;
    reg [31:0] wdata;
    reg [15:0] ee_data;
    reg [5:0] stream_format_code = 6'h20;
    wire [31:0] rdata;
    wire [11:0] fifo_fill;
    wire packet_complete, packet_sent, tx_start, no_reorder_tx, transport_stream_timestamp_on, video_timestamp_on;
    wire store_forward;
    integer err_count = 0, cmp_count = 0;
    initial {clk, nrst, wr, rd, ee_load, underrun, retries_zero, go, addr, wdata, ee_data} = 0;
    always #5 clk = ~clk;
    link_tuning link_tuning_inst (.*);
    tx_fifo_model tx_fifo_model_inst (.*);
    task check(input [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %0t %h %h", $time, s, e);
        end
    endtask
    task acc(input w, input [11:0] a, input [31:0] d, e);
        @(posedge clk);
        {wr, rd, addr, wdata} <= {w, !w, a, d};
        @(posedge clk);
        {wr, rd} <= 2'h0;
        @(negedge clk);
        check(rdata, e);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        stop_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        acc(0, 12'ha88, 0, 32'h1000);
        acc(1, 12'ha88, 32'hffffffff, 0);
        acc(0, 12'h0f4, 0, 32'hb582);
        check({no_reorder_tx, transport_stream_timestamp_on, video_timestamp_on}, 6);
        acc(1, 12'ha8c, 32'h0000a400, 0);
        acc(0, 12'ha8c, 0, 32'h1182);
        check({no_reorder_tx, transport_stream_timestamp_on, video_timestamp_on}, 0);
        acc(1, 12'ha88, 32'h00008400, 0);
        @(negedge clk) check(transport_stream_timestamp_on, 1);
        @(posedge clk);
        stream_format_code <= 6'h00;
        {ee_load, ee_data} <= 17'h10000;
        @(posedge clk) ee_load <= 1'h0;
        acc(0, 12'h100, 0, 0);
        check({transport_stream_timestamp_on, video_timestamp_on}, 1);
        acc(0, 12'ha88, 0, 32'h9500);
        acc(1, 12'ha88, 32'h00002000, 0);
        @(posedge clk);
        retries_zero <= 1'h1;
        go <= 1'h1;
        wait (tx_start === 1'h1);
        @(negedge clk);
        check({store_forward, tx_start, fifo_fill >= 12'h3c0, fifo_fill < 12'h6c0}, 4'hf);
        @(posedge clk);
        retries_zero <= 1'h0;
        underrun <= 1'h1;
        @(posedge clk) underrun <= 1'h0;
        @(negedge clk) check(store_forward, 0);
        @(posedge clk);
        @(negedge clk) check(store_forward, 1);
        acc(1, 12'ha8c, 32'h00002000, 0);
        acc(0, 12'ha8c, 0, 32'h9500);
        stop_test;
    end
endmodule // link_tuning_bench
